/* pkg/tfr_pkg.sv */
package tfr_pkg;
  // Command codes of the response settings
  localparam logic [7:0] CMD_EXT_OT = 8'h50;
  localparam logic [7:0] CMD_EXT_UT = 8'h54;
  localparam logic [7:0] CMD_DIE_OT = 8'hd6;
  // Reset values of the response settings
  localparam logic [7:0] EXT_RESET  = 8'hb8;
  localparam logic [7:0] DIE_RESET  = 8'hc0;
  // Page value that addresses every channel at once
  localparam logic [7:0] PAGE_ALL   = 8'hff;
  // Field positions inside a response byte
  localparam int RESP_HI  = 7;
  localparam int RESP_LO  = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  // Response field codes
  localparam logic [1:0] RESP_CONTINUE = 2'h0;
  localparam logic [1:0] RESP_UNSUP    = 2'h1;
  localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
  localparam logic [1:0] RESP_WHILE    = 2'h3;
  // Retry field codes
  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  // Channel count and restart counter width
  localparam int NUM_CHANNELS = 2;
  localparam int RESTART_W    = 16;

  // Channel output states
  typedef enum logic [3:0] {
    CH_RUN     = 4'b0001,
    CH_LATCHED = 4'b0010,
    CH_RETRY   = 4'b0100,
    CH_HOLD    = 4'b1000
  } tfr_ch_state_type;

  // Response field of a setting byte
  function automatic logic [1:0] tfr_resp(input logic [7:0] b);
    return b[RESP_HI:RESP_LO];
  endfunction

  // Retry field of a setting byte; the delay field is never looked at
  function automatic logic [2:0] tfr_retry(input logic [7:0] b);
    return b[RETRY_HI:RETRY_LO];
  endfunction
endpackage

/* logic/tfr_channel.sv */
`timescale 1ns/1ps
// Output control of one channel: shutdown, retry and hold-while-hot
module tfr_channel
  import tfr_pkg::*;
#(
  parameter int CNT_W = RESTART_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             channel_on,
  input  wire logic             die_fault,
  input  wire logic             adc_valid,
  input  wire logic             ext_ot_fault,
  input  wire logic             ext_ut_fault,
  input  wire logic [7:0]       die_resp,
  input  wire logic [7:0]       ot_resp,
  input  wire logic [7:0]       ut_resp,
  input  wire logic [CNT_W-1:0] restart_interval,
  input  wire logic             clear_faults,
  output logic                  output_enable,
  output logic                  turn_on
);
  // Whole channel state
  typedef struct packed {
    tfr_ch_state_type st;       // Output state
    logic [CNT_W-1:0] wait_cnt; // Cycles left before a restart
    logic             on_d;     // Command level one cycle ago
    logic             out_en;   // Registered output enable
  } tfr_ch_type;

  tfr_ch_type s;       // Current state
  tfr_ch_type next_s;  // Next state
  logic       die_shut; // Die fault asking for shutdown
  logic       die_hold; // Die fault asking for disable while present
  logic       ot_hit;   // Sampled external overtemperature shutdown
  logic       ut_hit;   // Sampled external undertemperature shutdown
  logic       ext_stop; // External shutdown that must not restart

  // Off-to-on edge of the combined run command
  assign turn_on       = channel_on & ~s.on_d;
  assign output_enable = s.out_en;

  // Next state
  always_comb begin
    next_s      = s;
    next_s.on_d = channel_on;
    die_shut    = die_fault & (tfr_resp(die_resp) == RESP_SHUTDOWN);
    die_hold    = die_fault & (tfr_resp(die_resp) == RESP_WHILE);
    // Code 00 lets the channel run on; the delay field is unused
    ot_hit   = adc_valid & ext_ot_fault
             & (tfr_resp(ot_resp) == RESP_SHUTDOWN);
    ut_hit   = adc_valid & ext_ut_fault
             & (tfr_resp(ut_resp) == RESP_SHUTDOWN);
    // Any retry code other than all ones means no restart
    ext_stop = (ot_hit & (tfr_retry(ot_resp) != RETRY_FOREVER))
             | (ut_hit & (tfr_retry(ut_resp) != RETRY_FOREVER));
    if (!channel_on) begin
      // Commanded off: forget any shutdown, restart is from scratch
      next_s.st       = CH_RUN;
      next_s.wait_cnt = '0;
    end else begin
      unique case (s.st)
        CH_RUN: begin
          if (die_shut) begin
            // Die retry field can only be 000: latch off
            next_s.st = CH_LATCHED;
          end else if (die_hold) begin
            next_s.st = CH_HOLD;
          end else if (ext_stop) begin
            next_s.st = CH_LATCHED;
          end else if (ot_hit | ut_hit) begin
            next_s.st       = CH_RETRY;
            next_s.wait_cnt = restart_interval;
          end
        end
        CH_LATCHED: begin
          // Stays off until the fault is cleared; a hot die still holds
          if (clear_faults) begin
            if (die_hold) begin
              next_s.st = CH_HOLD;
            end else if (!die_shut) begin
              next_s.st = CH_RUN;
            end
          end
        end
        CH_RETRY: begin
          // Another fault without retry ends the restart loop
          if (die_shut | ext_stop) begin
            next_s.st = CH_LATCHED;
          end else if (die_hold) begin
            next_s.st = CH_HOLD;
          end else if (s.wait_cnt == '0) begin
            next_s.st = CH_RUN;
          end else begin
            next_s.wait_cnt = s.wait_cnt - 1'b1;
          end
        end
        CH_HOLD: begin
          // External shutdowns taken while held off still count
          if (ext_stop) begin
            next_s.st = CH_LATCHED;
          end else if (ot_hit | ut_hit) begin
            next_s.st       = CH_RETRY;
            next_s.wait_cnt = restart_interval;
          end else if (!die_fault) begin
            // Re-enable as soon as the die cools down
            next_s.st = CH_RUN;
          end
        end
        default: begin
          // Illegal one-hot code: recover to running
          next_s.st = CH_RUN;
        end
      endcase
    end
    next_s.out_en = channel_on & (next_s.st == CH_RUN);
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '{st: CH_RUN, wait_cnt: '0, on_d: 1'b0, out_en: 1'b0};
    end else begin
      s <= next_s;
    end
  end
endmodule

/* logic/tfr_fault_response.sv */
`timescale 1ns/1ps
// How it works
// - Read-only die setting at 0xD6, reset 0xC0
// - Die fault sets MFR bits, alerts unless masked
// - Die response 00 or 01 raises CML fault
// - Die response 10 shuts down, latches off; fixed 0xC0 setting never selects it
// - Die response 11 disables while fault present
// - Retry 000 means stay off until cleared
// - Die retry 001 to 111 raises CML fault
// - Die delay field ignored
// - Flags clear on clear, off-on, reset
// - External OT setting 0x50, paged, reset 0xB8
// - External UT setting 0x54, paged, reset 0xB8
// - External OT sets temperature bits, alerts
// - External faults taken from ADC results
// - External 00 continues, 10 stops, else CML
// - External retry 111 restarts after interval
// - External delay field ignored
// - External UT sets temperature bits, alerts
module tfr_fault_response
  import tfr_pkg::*;
#(
  // Channel count and restart counter width
  parameter int NUM_CH = NUM_CHANNELS,
  parameter int CNT_W  = RESTART_W
) (
  // Clock and power-on reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Management command port
  input  wire logic              cmd_valid,
  input  wire logic              cmd_write,
  input  wire logic [7:0]        cmd_code,
  input  wire logic [7:0]        cmd_wdata,
  input  wire logic [7:0]        page_sel,
  // Command answer, one cycle after the request
  output logic                   cmd_ack,
  output logic                   cmd_hit,
  output logic [7:0]             cmd_rdata,
  output logic                   cml_fault,
  // Fault clear and per-channel run commands
  input  wire logic              clear_faults,
  input  wire logic [NUM_CH-1:0] channel_run_pin,
  input  wire logic [NUM_CH-1:0] operation_on,
  // Restart interval in clock cycles, shared by both channels
  input  wire logic [CNT_W-1:0]  restart_interval_setting,
  // Temperature sensing
  input  wire logic              die_overtemp,
  input  wire logic              adc_valid,
  input  wire logic [NUM_CH-1:0] ext_overtemp,
  input  wire logic [NUM_CH-1:0] ext_undertemp,
  // Alert masks, high hides a flag from the alert line
  input  wire logic              alert_mask_die,
  input  wire logic [NUM_CH-1:0] alert_mask_ot,
  input  wire logic [NUM_CH-1:0] alert_mask_ut,
  // Channel enables and status flags
  output logic [NUM_CH-1:0]      output_enable,
  output logic                   status_word_mfr,
  output logic                   status_mfr_overtemp,
  output logic [NUM_CH-1:0]      status_byte_temp,
  output logic [NUM_CH-1:0]      status_temp_ot,
  output logic [NUM_CH-1:0]      status_temp_ut,
  output logic                   alert_n
);
  // Whole register and flag state of the block
  // Settings, sticky flags and the registered command answer all live
  // here, so that one always_ff holds every flip-flop outside the channel controllers
  typedef struct packed {
    logic [NUM_CH-1:0][7:0] ot_resp; // External OT setting per channel
    logic [NUM_CH-1:0][7:0] ut_resp; // External UT setting per channel
    logic                   die_flag; // Die overtemperature status
    logic [NUM_CH-1:0]      ot_flag;  // External OT status per channel
    logic [NUM_CH-1:0]      ut_flag;  // External UT status per channel
    logic                   ack;      // Command answer strobe
    logic                   hit;      // Command code belongs here
    logic [7:0]             rdata;    // Read data
    logic                   cml;      // Rejected write strobe
    logic                   alert_n;  // Alert line, low when active
  } tfr_top_state_type;

  // Current and next copies of the whole state
  tfr_top_state_type s;      // Current state
  tfr_top_state_type next_s; // Next state

  // Die setting never changes; it is a constant register
  // Holding it as a constant saves eight flops; the price is that the
  // shutdown-and-latch die response can never be selected
  localparam logic [7:0] DIE_RESP = DIE_RESET;

  // Combinational helpers of the decode
  logic [NUM_CH-1:0] ch_on;   // Run pin and operation both asking on
  logic [NUM_CH-1:0] turn_on; // Off-to-on edge per channel
  logic [NUM_CH-1:0] ch_en;   // Output enable per channel
  logic              wr;      // Write request this cycle
  logic              rd;      // Read request this cycle
  logic [7:0]        rsel;    // Channel picked for a read
  logic              ext_ok;  // Written external byte is supported
  logic              die_ok;  // Written die byte is supported

  // Does a page value address a given channel
  // The all-pages value reaches every channel at once, so one write
  // can set both channels alike
  function automatic logic page_hits(input logic [7:0] page,
                                     input int         ch);
    return (page == PAGE_ALL) || (page == 8'(ch));
  endfunction

  // External byte legal: only continue or shutdown responses
  // Retry and delay fields never make an external byte illegal
  function automatic logic ext_legal(input logic [7:0] b);
    return (tfr_resp(b) == RESP_CONTINUE)
         || (tfr_resp(b) == RESP_SHUTDOWN);
  endfunction

  // Die byte legal: upper responses only, no retry count
  // The delay field is left out of the test on purpose
  // A legal byte is still not stored, the setting being read-only
  function automatic logic die_legal(input logic [7:0] b);
    return (tfr_resp(b) != RESP_CONTINUE)
         && (tfr_resp(b) != RESP_UNSUP)
         && (tfr_retry(b) == RETRY_NONE);
  endfunction

  // A channel counts as on only while the pin and the command agree
  assign ch_on  = channel_run_pin & operation_on;
  // Read and write strobes of the command port
  assign wr     = cmd_valid & cmd_write;
  assign rd     = cmd_valid & ~cmd_write;
  // Legality of the byte on the data lines, used only by writes
  assign ext_ok = ext_legal(cmd_wdata);
  assign die_ok = die_legal(cmd_wdata);
  // A read under the all-pages value answers from channel 0
  // and so does any page value beyond the last channel
  assign rsel   = (page_sel < 8'(NUM_CH)) ? page_sel : 8'h00;

  // Registered outputs
  // Every output below but status_byte_temp comes straight from a flip-flop, so the host
  // never sees a glitch while the command decode settles
  assign cmd_ack             = s.ack;
  assign cmd_hit             = s.hit;
  assign cmd_rdata           = s.rdata;
  assign cml_fault           = s.cml;
  // Channel enables come from the controllers' own flip-flops
  assign output_enable       = ch_en;
  // One die flag feeds both of its status bits
  assign status_word_mfr     = s.die_flag;
  assign status_mfr_overtemp = s.die_flag;
  // Summary bit of each channel: either temperature flag
  assign status_byte_temp    = s.ot_flag | s.ut_flag;
  assign status_temp_ot      = s.ot_flag;
  assign status_temp_ut      = s.ut_flag;
  // Active low, so the idle line is high
  assign alert_n             = s.alert_n;

  // One output controller per channel
  // The die sensor is shared, so both channels see the same die fault;
  // the external sensors and settings are kept per channel
  // Each controller owns its state machine and restart counter
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      tfr_channel #(
        .CNT_W (CNT_W)
      ) u_ch (
        .clk              (clk),
        .rst              (rst),
        .channel_on       (ch_on[g]),
        .die_fault        (die_overtemp),
        .adc_valid        (adc_valid),
        .ext_ot_fault     (ext_overtemp[g]),
        .ext_ut_fault     (ext_undertemp[g]),
        .die_resp         (DIE_RESP),
        .ot_resp          (s.ot_resp[g]),
        .ut_resp          (s.ut_resp[g]),
        .restart_interval (restart_interval_setting),
        .clear_faults     (clear_faults),
        .output_enable    (ch_en[g]),
        .turn_on          (turn_on[g])
      );
    end
  endgenerate

  // Command decode, settings, status flags and alert
  // Everything settles in this one process so that the flags, the
  // stored settings and the alert line always agree within a cycle
  always_comb begin
    next_s       = s;
    // Answer fields are pulses: cleared unless a request sets them
    next_s.ack   = cmd_valid;
    next_s.cml   = 1'b0;
    next_s.hit   = 1'b0;
    next_s.rdata = 8'h00;

    // Commands: settings and read-back
    // Every request is answered, ours or not, so the host never waits
    if (cmd_valid) begin
      unique case (cmd_code)
        CMD_EXT_OT: begin
          // External overtemperature setting of the read channel
          next_s.hit   = 1'b1;
          next_s.rdata = s.ot_resp[rsel[0 +: $clog2(NUM_CH)]];
          if (wr) begin
            // A rejected byte is not stored
            next_s.cml = ~ext_ok;
          end
        end
        CMD_EXT_UT: begin
          // External undertemperature setting of the read channel
          next_s.hit   = 1'b1;
          next_s.rdata = s.ut_resp[rsel[0 +: $clog2(NUM_CH)]];
          if (wr) begin
            // Same refusal as the overtemperature setting
            next_s.cml = ~ext_ok;
          end
        end
        CMD_DIE_OT: begin
          // Fixed die setting; reads never depend on the page
          next_s.hit   = 1'b1;
          next_s.rdata = DIE_RESP;
          if (wr) begin
            // Read-only: a legal byte is dropped, a bad one flagged
            next_s.cml = ~die_ok;
          end
        end
        default: begin
          // Other command codes are handled elsewhere
          // Their answer carries ack with hit low, so the host can tell them apart
          next_s.hit = 1'b0;
        end
      endcase
    end
    // Read data is zero on writes and idle cycles, never stale
    if (!rd) begin
      next_s.rdata = 8'h00;
    end

    // Per-channel settings and flags
    // Writes land only in the channels that the page selects, and only
    // when the byte is legal, so a refused byte leaves the old value
    for (int c = 0; c < NUM_CH; c++) begin
      if (wr && ext_ok && page_hits(page_sel, c)) begin
        if (cmd_code == CMD_EXT_OT) begin
          next_s.ot_resp[c] = cmd_wdata;
        end
        // Each setting has its own command code
        if (cmd_code == CMD_EXT_UT) begin
          next_s.ut_resp[c] = cmd_wdata;
        end
      end
      // Clear-faults and an off-to-on edge both restart the flags
      // Clear first, so that a fault in the same cycle wins
      if (clear_faults || turn_on[c]) begin
        next_s.ot_flag[c] = 1'b0;
        next_s.ut_flag[c] = 1'b0;
      end
      // Faults are seen only on ADC result strobes
      // Between strobes the compare inputs may be stale, so they wait
      if (adc_valid && ext_overtemp[c]) begin
        next_s.ot_flag[c] = 1'b1;
      end
      // Undertemperature follows the same strobe
      if (adc_valid && ext_undertemp[c]) begin
        next_s.ut_flag[c] = 1'b1;
      end
    end

    // Die flag is shared by both channels
    // A turn-on of either channel clears it; set still wins over clear,
    // so a restart of one channel also frees the other's die status
    if (clear_faults || (|turn_on)) begin
      next_s.die_flag = 1'b0;
    end
    // The die sensor is a level, taken on every edge
    if (die_overtemp) begin
      next_s.die_flag = 1'b1;
    end

    // Alert follows any unmasked flag at the same edge as the flag
    // Masks only hide a flag from the alert line; the flag still sets
    // A masked flag can still raise the alert once its mask drops
    next_s.alert_n = ~((next_s.die_flag & ~alert_mask_die)
                     | (|(next_s.ot_flag & ~alert_mask_ot))
                     | (|(next_s.ut_flag & ~alert_mask_ut)));
  end

  // State register; power-on reset restores defaults and clears flags
  // Reset values are constants only, so the asynchronous branch holds
  // no logic that could glitch while reset is released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s          <= '0;
      // Settings come back to their defaults on every channel
      s.ot_resp  <= {NUM_CH{EXT_RESET}};
      s.ut_resp  <= {NUM_CH{EXT_RESET}};
      // Alert line idles high
      s.alert_n  <= 1'b1;
    end else begin
      // Every flip-flop takes its next value on every edge
      s <= next_s;
    end
  end
endmodule

/* bench/tfr_fault_response_assertions.sv */
`timescale 1ns/1ps
// Port-level checks of the temperature fault response block
module tfr_fault_response_assertions
  import tfr_pkg::*;
#(
  parameter int NUM_CH = NUM_CHANNELS
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              cmd_valid,
  input wire logic              cmd_write,
  input wire logic [7:0]        cmd_code,
  input wire logic [7:0]        cmd_wdata,
  input wire logic              cmd_ack,
  input wire logic [7:0]        cmd_rdata,
  input wire logic              cml_fault,
  input wire logic              clear_faults,
  input wire logic [NUM_CH-1:0] channel_run_pin,
  input wire logic [NUM_CH-1:0] operation_on,
  input wire logic              die_overtemp,
  input wire logic              adc_valid,
  input wire logic [NUM_CH-1:0] ext_overtemp,
  input wire logic              alert_mask_die,
  input wire logic [NUM_CH-1:0] output_enable,
  input wire logic              status_word_mfr,
  input wire logic              status_mfr_overtemp,
  input wire logic [NUM_CH-1:0] status_byte_temp,
  input wire logic [NUM_CH-1:0] status_temp_ot,
  input wire logic              alert_n
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Channel 0 counts as on only with both the pin and the command
  wire logic ch0_on = channel_run_pin[0] & operation_on[0];

  chk_die_read_fixed: assert property (
    cmd_valid && !cmd_write && cmd_code == CMD_DIE_OT
    |=> cmd_ack && cmd_rdata == DIE_RESET) else $error("die read wrong");
  chk_die_resp_cml: assert property (
    cmd_valid && cmd_write && cmd_code == CMD_DIE_OT && !cmd_wdata[7]
    |=> cml_fault) else $error("die response not refused");
  chk_die_retry_cml: assert property (
    cmd_valid && cmd_write && cmd_code == CMD_DIE_OT
    && cmd_wdata[5:3] != 3'h0 |=> cml_fault) else $error("die retry taken");
  chk_ext_resp_cml: assert property (
    cmd_valid && cmd_write && cmd_wdata[6]
    && (cmd_code == CMD_EXT_OT || cmd_code == CMD_EXT_UT)
    |=> cml_fault) else $error("ext response not refused");
  chk_die_flags_set: assert property (
    die_overtemp |=> status_word_mfr && status_mfr_overtemp)
    else $error("die flags not set");
  chk_die_alert_low: assert property (
    die_overtemp && !alert_mask_die |=> !alert_n) else $error("no alert");
  chk_die_shut_down: assert property (
    die_overtemp |=> output_enable == '0) else $error("die no shutdown");
  chk_ext_ot_flags: assert property (
    adc_valid && ext_overtemp[0] |=> status_temp_ot[0] && status_byte_temp[0])
    else $error("ext flags not set");
  chk_ot_flag_sticky: assert property (
    status_temp_ot[0] && !clear_faults && ch0_on && $past(ch0_on)
    |=> status_temp_ot[0]) else $error("flag dropped");
  chk_ext_adc_only: assert property (
    !adc_valid && !status_temp_ot[0] |=> !status_temp_ot[0])
    else $error("flag without adc strobe");
endmodule

bind tfr_fault_response tfr_fault_response_assertions #(
  .NUM_CH(NUM_CH)) i_tfr_fault_response_assertions (.*);

/* bench/tfr_host.sv */
`timescale 1ns/1ps
// Behavioural management-bus host: one byte command per call
module tfr_host (
  input  wire logic       clk,
  output logic            cmd_valid,
  output logic            cmd_write,
  output logic [7:0]      cmd_code,
  output logic [7:0]      cmd_wdata,
  output logic [7:0]      page_sel,
  input  wire logic       cmd_ack,
  input  wire logic       cmd_hit,
  input  wire logic [7:0] cmd_rdata,
  input  wire logic       cml_fault
);
  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 8'h00;
    page_sel  = 8'h00;
  end

  // Request held over the taking edge; answer {ack,hit,cml,rdata}
  task automatic xfer(input logic w, input logic [7:0] code, data, page,
                      output logic [10:0] ans);
    @(posedge clk);
    #2;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code  = code;
    cmd_wdata = data;
    page_sel  = page;
    @(posedge clk);
    #2;
    cmd_valid = 1'b0;
    // Released lines show the inverse so stale values never look valid
    cmd_code  = ~code;
    cmd_wdata = ~data;
    ans = {cmd_ack, cmd_hit, cml_fault, cmd_rdata};
  endtask
endmodule

/* bench/test_tfr_fault_response.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
// Self-checking bench of the temperature fault response block
module test_tfr_fault_response;
  import tfr_pkg::*;
  logic        clk, rst, cmd_valid, cmd_write, cmd_ack, cmd_hit, cml_fault;
  logic [7:0]  cmd_code, cmd_wdata, page_sel, cmd_rdata;
  logic        clear_faults, die_overtemp, adc_valid, alert_mask_die;
  logic [1:0]  channel_run_pin, operation_on, ext_overtemp, ext_undertemp;
  logic [1:0]  alert_mask_ot, alert_mask_ut, output_enable, status_byte_temp;
  logic [1:0]  status_temp_ot, status_temp_ut;
  logic        status_word_mfr, status_mfr_overtemp, alert_n;
  logic [15:0] restart_interval_setting;
  logic [10:0] ans;
  int          err_count, total_checks, n;

  tfr_fault_response i_tfr_fault_response (.*);
  tfr_host i_tfr_host (.*);

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Step k edges, then let that edge's updates land
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask

  task automatic complete_run;
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic pulse_clear;
    clear_faults = 1'b1;
    tick(1);
    clear_faults = 1'b0;
    tick(2);
  endtask

  // Reset contents, read-only die setting, unknown code
  task automatic t_reset_values;
    i_tfr_host.xfer(0, CMD_EXT_OT, 0, 0, ans); `CHK(ans, {3'h6, EXT_RESET})
    i_tfr_host.xfer(0, CMD_EXT_UT, 0, 1, ans); `CHK(ans, {3'h6, EXT_RESET})
    i_tfr_host.xfer(0, CMD_DIE_OT, 0, 1, ans); `CHK(ans, {3'h6, DIE_RESET})
    i_tfr_host.xfer(0, 8'h99, 0, 0, ans); `CHK(ans, 11'h400)
  endtask

  // Every die response and retry code, every ext response written; refused ones leave the setting
  task automatic t_writes;
    logic [7:0] d;
    i_tfr_host.xfer(1, CMD_EXT_OT, 8'h80, 1, ans); `CHK(ans[9:8], 2'h2)
    for (int r = 0; r < 4; r++) begin
      for (int t = 0; t < 8; t++) begin
        d = {r[1:0], t[2:0], 3'h5};
        i_tfr_host.xfer(1, CMD_DIE_OT, d, 0, ans);
        `CHK(ans[8], r < 2 || t != 0)
      end
      d = {r[1:0], 6'h3d};
      i_tfr_host.xfer(1, CMD_EXT_OT, d, 0, ans); `CHK(ans[8], r[0])
    end
    // Last accepted ext byte is 0xbd: shutdown, retry forever
    i_tfr_host.xfer(0, CMD_EXT_OT, 0, 0, ans); `CHK(ans[7:0], 8'hbd)
    i_tfr_host.xfer(0, CMD_EXT_OT, 0, 1, ans); `CHK(ans[7:0], 8'h80)
    i_tfr_host.xfer(0, CMD_DIE_OT, 0, 0, ans); `CHK(ans[7:0], DIE_RESET)
  endtask

  // Die fault: flags, alert, output held off only while hot
  task automatic t_die_fault;
    die_overtemp = 1'b1;
    tick(1);
    die_overtemp = 1'b0;
    `CHK({status_word_mfr, status_mfr_overtemp, alert_n}, 3'h6)
    `CHK(output_enable, 2'h0)
    tick(4);
    `CHK({status_mfr_overtemp, output_enable}, 3'h7)
    pulse_clear();
    `CHK({status_mfr_overtemp, alert_n, output_enable}, 4'h7)
  endtask

  // Ext continue response with a masked alert; strobe gating
  task automatic t_ext_continue;
    i_tfr_host.xfer(1, CMD_EXT_UT, 8'h07, 0, ans); `CHK(ans[8], 1'b0)
    ext_overtemp = 2'h2;
    tick(3);
    `CHK(status_temp_ot, 2'h0)
    ext_overtemp = 2'h0;
    alert_mask_ut = 2'h1;
    ext_undertemp = 2'h1;
    adc_valid = 1'b1;
    tick(1);
    adc_valid = 1'b0;
    ext_undertemp = 2'h0;
    `CHK({status_temp_ut, status_byte_temp, alert_n}, 5'h0b)
    tick(4);
    `CHK(output_enable, 2'h3)
    pulse_clear();
    alert_mask_ut = 2'h0;
  endtask

  // Ch0 restarts after the interval, ch1 latches until off-on
  task automatic t_ext_retry;
    ext_overtemp = 2'h3;
    adc_valid = 1'b1;
    tick(1);
    adc_valid = 1'b0;
    ext_overtemp = 2'h0;
    `CHK({status_temp_ot, alert_n, output_enable}, 5'h18)
    n = 0;
    while (output_enable[0] !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    `CHK(n >= 4 && n <= 6, 1'b1)
    `CHK({status_temp_ot, output_enable[1]}, 3'h6)
    channel_run_pin[1] = 1'b0;
    tick(2);
    channel_run_pin[1] = 1'b1;
    tick(3);
    `CHK({status_temp_ot, output_enable}, 4'h7)
    pulse_clear();
  endtask

  // Watchdog well beyond the expected run time
  initial begin
    #200000;
    err_count++;
    complete_run();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    {clear_faults, die_overtemp, adc_valid, alert_mask_die} = 4'h0;
    {ext_overtemp, ext_undertemp, alert_mask_ot, alert_mask_ut} = 8'h00;
    channel_run_pin = 2'h3;
    operation_on = 2'h3;
    restart_interval_setting = 16'h0004;
    repeat (6) @(posedge clk);
    #2;
    rst = 1'b0;
    tick(3);
    t_reset_values();
    t_writes();
    t_die_fault();
    t_ext_continue();
    t_ext_retry();
    complete_run();
  end
endmodule
